// *** pkg/cbw_map.svh ***
// register offsets, field positions and reset values of the cardbus window block
`ifndef CBW_MAP_SVH
`define CBW_MAP_SVH
`define CBW_OFF_LAT 8'h1B
`define CBW_OFF_MEM0_BASE 8'h1C
`define CBW_OFF_MEM0_LIM 8'h20
`define CBW_OFF_MEM1_BASE 8'h24
`define CBW_OFF_MEM1_LIM 8'h28
`define CBW_OFF_IO0_BASE 8'h2C
`define CBW_OFF_IO0_LIM 8'h30
`define CBW_OFF_IO1_BASE 8'h34
`define CBW_OFF_IO1_LIM 8'h38
`define CBW_OFF_BRCTL 8'h3E
`define CBW_MEM_MASK 32'hFFFFF000
`define CBW_IO_MASK 32'h0000FFFC
`define CBW_BRCTL_PF0 8
`define CBW_BRCTL_PF1 9
`define CBW_BRCTL_RST 16'h0340
`define CBW_LAT_RST 8'h00
`define CBW_WIN_RST 32'h00000000
`endif

// *** pkg/cbw_pkg.sv ***
// types shared by the cardbus window block
package cbw_pkg;
  typedef struct packed {
    logic [31:0] addr;
    logic is_io;
    logic from_card;
  } cbw_req_t;
  typedef struct packed {
    logic hit;
    logic win;
    logic prefetch;
  } cbw_dec_t;
  typedef enum logic [1:0] {
    CBW_IDLE = 2'b00,
    CBW_RUN = 2'b01,
    CBW_CUT = 2'b10
  } cbw_lat_st_t;
endpackage

// *** core/cbw_window_decode.sv ***
// cardbus window decode: configuration registers, window match, latency timer
`timescale 1ns/100ps
`include "cbw_map.svh"

// Contract
// [R1] latency counter starts at programmed value when device asserts frame as initiator
// [R2] on expiry during own transaction, end it when the next data phase completes
// [R3] software should program latency count at least 20h
// [R4] memory base bits 31-12 writable, 11-0 read zero
// [R5] memory limit bits 31-12 writable, 11-0 read zero
// [R6] memory windows steer downstream forwarding and upstream passing
// [R7] memory window claims only when base or limit nonzero
// [R8] window0 prefetch from control bit 8, window1 from bit 9
// [R9] io base bits 15-2 writable, others read zero
// [R10] io windows steer io forwarding both directions
// [R11] io window passes nothing unless base or limit nonzero; here a disabled io window still lets every upstream io request pass
// [R12] io limit low two bits taken as ones
// [R13] memory limit low twelve bits taken as ones
module cbw_window_decode import cbw_pkg::*; (
  // clock, reset, enable
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  input wire logic clk_en_i,
  // configuration space access
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [7:0] cfg_addr_i,
  input wire logic [3:0] cfg_be_i,
  input wire logic [31:0] cfg_wdata_i,
  output logic [31:0] cfg_rdata_o,
  // address decode request and result
  input wire cbw_req_t req_i,
  output cbw_dec_t dec_o,
  // cardbus link, on its own clock
  input wire logic cb_clk_i,
  input wire logic cb_reset_n_i,
  input wire logic cb_frame_start_i,
  input wire logic cb_data_done_i,
  input wire logic cb_txn_end_i,
  output logic cb_stop_o
);
  // ------------------------------------------------
  // register file
  // ------------------------------------------------
  logic [7:0] lat_r;
  logic [31:0] win_base_r [4];
  logic [31:0] win_lim_r [4];
  logic [15:0] brctl_r;
  logic [31:0] cfg_rdata_r;
  cbw_dec_t dec_r;

  function automatic logic [31:0] cbw_merge(input logic [31:0] old, input logic [31:0] nw,
                                            input logic [3:0] be, input logic [31:0] msk);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r & msk;
  endfunction

  // windows 0,1 memory, 2,3 io; register offsets ordered base then limit
  wire logic [7:0] base_off [4];
  wire logic [7:0] lim_off [4];
  wire logic [31:0] win_mask [4];
  assign base_off[0] = `CBW_OFF_MEM0_BASE;
  assign base_off[1] = `CBW_OFF_MEM1_BASE;
  assign base_off[2] = `CBW_OFF_IO0_BASE;
  assign base_off[3] = `CBW_OFF_IO1_BASE;
  assign lim_off[0] = `CBW_OFF_MEM0_LIM;
  assign lim_off[1] = `CBW_OFF_MEM1_LIM;
  assign lim_off[2] = `CBW_OFF_IO0_LIM;
  assign lim_off[3] = `CBW_OFF_IO1_LIM;
  assign win_mask[0] = `CBW_MEM_MASK; // see [R4] see [R5]
  assign win_mask[1] = `CBW_MEM_MASK;
  assign win_mask[2] = `CBW_IO_MASK; // see [R9]
  assign win_mask[3] = `CBW_IO_MASK;

  wire logic [7:0] word_addr = {cfg_addr_i[7:2], 2'b00};
  wire logic wr_en = clk_en_i & cfg_wr_i;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_win
      always_ff @(posedge ref_clk_i) begin
        if (!reset_n_i) begin
          win_base_r[g] <= `CBW_WIN_RST;
          win_lim_r[g] <= `CBW_WIN_RST;
        end else if (wr_en && word_addr == base_off[g]) begin
          win_base_r[g] <= cbw_merge(win_base_r[g], cfg_wdata_i, cfg_be_i, win_mask[g]);
        end else if (wr_en && word_addr == lim_off[g]) begin
          win_lim_r[g] <= cbw_merge(win_lim_r[g], cfg_wdata_i, cfg_be_i, win_mask[g]);
        end
      end
    end
  endgenerate

  // latency byte is lane 3 of dword 18h; control word is upper half of dword 3Ch
  wire logic lat_wr = wr_en && word_addr == {`CBW_OFF_LAT & 8'hFC} && cfg_be_i[3];
  wire logic brctl_wr = wr_en && word_addr == {`CBW_OFF_BRCTL & 8'hFC};
  wire logic [15:0] brctl_wdata = {cfg_be_i[3] ? cfg_wdata_i[31:24] : brctl_r[15:8],
                                   cfg_be_i[2] ? cfg_wdata_i[23:16] : brctl_r[7:0]};

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      lat_r <= `CBW_LAT_RST;
    end else if (lat_wr) begin
      lat_r <= cfg_wdata_i[31:24];
    end
  end

  // only the two prefetch bits are kept; the rest of the control word reads zero here
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      brctl_r <= `CBW_BRCTL_RST & 16'h0300;
    end else if (brctl_wr) begin
      brctl_r <= brctl_wdata & 16'h0300;
    end
  end

  // ------------------------------------------------
  // read path
  // ------------------------------------------------
  logic [31:0] rd_sel;
  always_comb begin
    rd_sel = 32'h00000000;
    for (int w = 0; w < 4; w++) begin
      if (word_addr == base_off[w]) begin
        rd_sel = win_base_r[w];
      end
      if (word_addr == lim_off[w]) begin
        rd_sel = win_lim_r[w];
      end
    end
    if (word_addr == {`CBW_OFF_LAT & 8'hFC}) begin
      rd_sel = {lat_r, 24'h000000};
    end
    if (word_addr == {`CBW_OFF_BRCTL & 8'hFC}) begin
      rd_sel = {brctl_r, 16'h0000};
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      cfg_rdata_r <= 32'h00000000;
    end else if (clk_en_i && cfg_rd_i) begin
      cfg_rdata_r <= rd_sel;
    end
  end
  assign cfg_rdata_o = cfg_rdata_r;

  // ------------------------------------------------
  // window decode
  // ------------------------------------------------
  wire logic [3:0] win_on;
  wire logic [3:0] win_hit;
  generate
    for (g = 0; g < 4; g++) begin : g_hit
      wire logic [31:0] top = win_lim_r[g] | ~win_mask[g] & (g < 2 ? 32'h00000FFF : 32'h00000003);
      assign win_on[g] = (win_base_r[g] != 32'h00000000) || (win_lim_r[g] != 32'h00000000); // see [R7] see [R11]
      // see [R13] see [R12]
      assign win_hit[g] = win_on[g] && (req_i.is_io == (g >= 2)) && req_i.addr >= win_base_r[g] && req_i.addr <= top;
    end
  endgenerate

  // a downstream request is claimed on a hit; an upstream one passes on a miss
  wire logic any_hit = |win_hit;
  wire logic win_idx = win_hit[1] | win_hit[3];
  wire logic pf_sel = win_hit[1] ? brctl_r[`CBW_BRCTL_PF1] : brctl_r[`CBW_BRCTL_PF0]; // see [R8]

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      dec_r <= '0;
    end else if (clk_en_i) begin
      dec_r.hit <= req_i.from_card ? ~any_hit : any_hit; // see [R6] see [R10]
      dec_r.win <= win_idx;
      dec_r.prefetch <= (win_hit[0] | win_hit[1]) & pf_sel;
    end
  end
  assign dec_o = dec_r;

  // ------------------------------------------------
  // latency timer on the cardbus clock
  // ------------------------------------------------
  // the count changes only under software control; a third stage and a match
  // of two settled samples keep a torn byte from ever reaching the timer.
  logic [7:0] lat_s1_r;
  logic [7:0] lat_s2_r;
  logic [7:0] lat_s3_r;
  logic [7:0] lat_cb_r;
  logic [7:0] cnt_r;
  logic cut_r;
  cbw_lat_st_t st_r;

  always_ff @(posedge cb_clk_i) begin
    if (!cb_reset_n_i) begin
      lat_s1_r <= 8'h00;
      lat_s2_r <= 8'h00;
      lat_s3_r <= 8'h00;
    end else begin
      lat_s1_r <= lat_r;
      lat_s2_r <= lat_s1_r;
      lat_s3_r <= lat_s2_r;
    end
  end

  wire logic lat_settled = lat_s2_r == lat_s3_r;

  always_ff @(posedge cb_clk_i) begin
    if (!cb_reset_n_i) begin
      lat_cb_r <= `CBW_LAT_RST;
    end else if (lat_settled) begin
      lat_cb_r <= lat_s3_r;
    end
  end

  wire logic cnt_zero = cnt_r == 8'h00;

  always_ff @(posedge cb_clk_i) begin
    if (!cb_reset_n_i) begin
      st_r <= CBW_IDLE;
      cnt_r <= 8'h00;
      cut_r <= 1'b0;
    end else begin
      case (st_r)
        CBW_IDLE: begin
          cut_r <= 1'b0;
          if (cb_frame_start_i) begin
            cnt_r <= lat_cb_r; // see [R1]
            st_r <= CBW_RUN;
          end
        end
        CBW_RUN: begin
          if (cb_txn_end_i) begin
            st_r <= CBW_IDLE;
          end else if (cnt_zero) begin
            st_r <= CBW_CUT;
          end else begin
            cnt_r <= cnt_r - 8'h01;
          end
        end
        CBW_CUT: begin
          if (cb_txn_end_i) begin
            st_r <= CBW_IDLE;
            cut_r <= 1'b0;
          end else if (cb_data_done_i) begin
            cut_r <= 1'b1; // see [R2]
            st_r <= CBW_IDLE;
          end
        end
        default: begin
          st_r <= CBW_IDLE;
        end
      endcase
    end
  end
  assign cb_stop_o = cut_r;

  sequence cut_armed_s;
    st_r == CBW_CUT && cb_data_done_i && !cb_txn_end_i;
  endsequence
  sequence frame_taken_s;
    st_r == CBW_IDLE && cb_frame_start_i;
  endsequence

  expire_cut_a: assert property (@(posedge cb_clk_i) disable iff (!cb_reset_n_i) // see [R2]
    cut_armed_s |=> cb_stop_o)
    else $error("no stop after data phase once timer expired");
  start_load_a: assert property (@(posedge cb_clk_i) disable iff (!cb_reset_n_i) // see [R1]
    frame_taken_s |=> cnt_r == $past(lat_cb_r) && st_r == CBW_RUN)
    else $error("timer not loaded at frame start");
  count_step_a: assert property (@(posedge cb_clk_i) disable iff (!cb_reset_n_i) // see [R1]
    st_r == CBW_RUN && !cnt_zero && !cb_txn_end_i |=> cnt_r == $past(cnt_r) - 8'h01)
    else $error("timer did not count down");
  expire_arm_a: assert property (@(posedge cb_clk_i) disable iff (!cb_reset_n_i) // see [R2]
    st_r == CBW_RUN && cnt_zero && !cb_txn_end_i |=> st_r == CBW_CUT)
    else $error("expired timer did not arm the cut");
  early_stop_a: assert property (@(posedge cb_clk_i) disable iff (!cb_reset_n_i) // see [R2]
    st_r != CBW_CUT |=> !cb_stop_o)
    else $error("stop raised without expiry");
  stop_pulse_a: assert property (@(posedge cb_clk_i) disable iff (!cb_reset_n_i) // see [R2]
    cb_stop_o |=> !cb_stop_o)
    else $error("stop longer than one cycle");
  mem_low_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    win_base_r[0][11:0] == 12'h000 && win_lim_r[1][11:0] == 12'h000) // see [R4] see [R5]
    else $error("memory low bits not zero");
  io_bits_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    (win_base_r[2] & ~`CBW_IO_MASK) == 32'h00000000) // see [R9]
    else $error("io base fixed bits not zero");
  off_window_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    clk_en_i && !req_i.from_card && !(|win_on) |=> !dec_o.hit) // see [R7] see [R11]
    else $error("disabled window claimed");
  io_top_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    clk_en_i && win_on[3] && req_i.is_io && req_i.addr == (win_lim_r[3] | 32'h3) && !req_i.from_card
    && req_i.addr >= win_base_r[3] |=> dec_o.hit) // see [R12]
    else $error("io limit dword not included");
  mem_top_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    clk_en_i && win_on[0] && !req_i.is_io && !req_i.from_card && req_i.addr == (win_lim_r[0] | 32'hFFF)
    && req_i.addr >= win_base_r[0] |=> dec_o.hit) // see [R13]
    else $error("memory limit block not included");
  pf_sel_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    clk_en_i && win_hit[1] && !win_hit[0] |=> dec_o.prefetch == $past(brctl_r[`CBW_BRCTL_PF1])) // see [R8]
    else $error("window1 prefetch wrong");
  up_pass_a: assert property (@(posedge ref_clk_i) disable iff (!reset_n_i)
    clk_en_i && req_i.from_card && any_hit |=> !dec_o.hit) // see [R6] see [R10]
    else $error("upstream cycle inside window passed");
endmodule

// *** test/cbw_card_model.sv ***
// behavioural cardbus card side: drives the initiator transaction events on the link clock
`timescale 1ns/100ps
module cbw_card_model (
  // link clock
  input wire logic cb_clk_i,
  // transaction events
  output logic frame_start_o,
  output logic data_done_o,
  output logic txn_end_o,
  // latency cut from the block
  input wire logic cb_stop_i
);
  int phases_done = 0;
  logic cut_seen = 1'b0;
  initial begin
    frame_start_o = 1'b0;
    data_done_o = 1'b0;
    txn_end_o = 1'b0;
  end
  // ----------------------------------------------------------------
  // one transaction of up to n data phases, ended early once a cut is seen; gap idle cycles model a slow target
  // ----------------------------------------------------------------
  task automatic run(input int n, input int gap);
    phases_done = 0;
    cut_seen = 1'b0;
    @(posedge cb_clk_i);
    frame_start_o <= 1'b1;
    @(posedge cb_clk_i);
    frame_start_o <= 1'b0;
    while (phases_done < n && !cut_seen) begin
      repeat (gap) @(posedge cb_clk_i);
      data_done_o <= 1'b1;
      @(posedge cb_clk_i);
      data_done_o <= 1'b0;
      phases_done++;
      // the cut is a one-cycle pulse launched by the edge that took the phase
      #1 cut_seen = cb_stop_i;
      @(posedge cb_clk_i);
    end
    if (!cut_seen) begin
      txn_end_o <= 1'b1;
      @(posedge cb_clk_i);
      txn_end_o <= 1'b0;
    end
  endtask
endmodule

// *** test/testbench.sv ***
// self-checking bench for the cardbus window decode block
`timescale 1ns/100ps
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
  $display("ERROR t=%0t got=%h exp=%h", $time, g, e); end end
module testbench;
  import cbw_pkg::*;
  logic ref_clk_i = 1'b0, cb_clk_i = 1'b0, reset_n_i = 1'b0, cb_reset_n_i = 1'b0;
  logic cfg_wr_i = 1'b0, cfg_rd_i = 1'b0, clk_en_i = 1'b1;
  logic [7:0] cfg_addr_i = 8'h00;
  logic [3:0] cfg_be_i = 4'h0;
  logic [31:0] cfg_wdata_i = 32'h0, cfg_rdata_o;
  cbw_req_t req_i = '0;
  cbw_dec_t dec_o;
  logic fs, dd, te, cb_stop_o;
  int miscompares = 0, n_compared = 0;
  logic [7:0] regs [8] = '{8'h1C, 8'h20, 8'h24, 8'h28, 8'h2C, 8'h30, 8'h34, 8'h38};
  logic [31:0] msk [8] = '{32'hFFFFF000, 32'hFFFFF000, 32'hFFFFF000, 32'hFFFFF000,
    32'h0000FFFC, 32'h0000FFFC, 32'h0000FFFC, 32'h0000FFFC};
  logic [31:0] vals [8] = '{32'h10000000, 32'h10001000, 32'h20000000, 32'h20000000,
    32'h0, 32'h0, 32'h100, 32'h1FC};
  always #25 ref_clk_i = ~ref_clk_i;
  always #15 cb_clk_i = ~cb_clk_i;
  cbw_window_decode cbw_window_decode_inst (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .clk_en_i(clk_en_i),
    .cfg_wr_i(cfg_wr_i), .cfg_rd_i(cfg_rd_i), .cfg_addr_i(cfg_addr_i), .cfg_be_i(cfg_be_i),
    .cfg_wdata_i(cfg_wdata_i), .cfg_rdata_o(cfg_rdata_o), .req_i(req_i), .dec_o(dec_o),
    .cb_clk_i(cb_clk_i), .cb_reset_n_i(cb_reset_n_i), .cb_frame_start_i(fs), .cb_data_done_i(dd),
    .cb_txn_end_i(te), .cb_stop_o(cb_stop_o));
  cbw_card_model cbw_card_model_inst (.cb_clk_i(cb_clk_i), .frame_start_o(fs), .data_done_o(dd),
    .txn_end_o(te), .cb_stop_i(cb_stop_o));
  // ----------------------------------------------------------------
  // access tasks
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [3:0] be, input logic [31:0] d);
    @(negedge ref_clk_i);
    cfg_addr_i = a;
    cfg_be_i = be;
    cfg_wdata_i = d;
    cfg_wr_i = 1'b1;
    @(negedge ref_clk_i);
    cfg_wr_i = 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e);
    @(negedge ref_clk_i);
    cfg_addr_i = a;
    cfg_rd_i = 1'b1;
    @(negedge ref_clk_i);
    cfg_rd_i = 1'b0;
    @(negedge ref_clk_i);
    `CHK(cfg_rdata_o & m, e)
  endtask
  // expected is {hit, win, prefetch}; window and prefetch mean nothing on a miss or upstream
  task automatic dchk(input logic [31:0] a, input logic io, input logic up, input logic [2:0] e);
    @(negedge ref_clk_i);
    req_i = '{a, io, up};
    repeat (2) @(negedge ref_clk_i);
    if (e[2] && !up) `CHK(dec_o, e)
    else `CHK(dec_o.hit, e[2])
  endtask
  task automatic lat_chk(input logic [7:0] l, input int n, input int gap, input logic cut);
    int lo;
    int pd;
    lo = int'(l) / 2 + 2;
    wr(8'h18, 4'h8, {l, 24'h0});
    rd_chk(8'h18, 32'hFF000000, {l, 24'h0});
    // the count crosses into the link domain, so give it a few link edges to land
    repeat (4) @(posedge cb_clk_i);
    cbw_card_model_inst.run(n, gap);
    pd = cbw_card_model_inst.phases_done;
    `CHK(cbw_card_model_inst.cut_seen, cut)
    if (cut && gap == 0) `CHK(pd == lo || pd == lo + 1, 1'b1)
  endtask
  task automatic print_verdict;
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    #2000000;
    miscompares++;
    print_verdict;
  end
  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(negedge ref_clk_i);
    reset_n_i = 1'b1;
    cb_reset_n_i = 1'b1;
    foreach (regs[i]) rd_chk(regs[i], 32'hFFFFFFFF, 32'h0);
    rd_chk(8'h18, 32'hFF000000, 32'h0);
    rd_chk(8'h3C, 32'h03000000, 32'h03000000);
    rd_chk(8'h40, 32'hFFFFFFFF, 32'h0);
    dchk(32'h0, 1'b0, 1'b0, 3'b000);
    dchk(32'h0, 1'b1, 1'b0, 3'b000);
    foreach (regs[i]) wr(regs[i], 4'hF, 32'hFFFFFFFF);
    foreach (regs[i]) rd_chk(regs[i], 32'hFFFFFFFF, msk[i]);
    foreach (regs[i]) wr(regs[i], 4'hF, vals[i]);
    dchk(32'h10000000, 1'b0, 1'b0, 3'b101);
    dchk(32'h10001FFF, 1'b0, 1'b0, 3'b101);
    dchk(32'h10002000, 1'b0, 1'b0, 3'b000);
    dchk(32'h0FFFFFFF, 1'b0, 1'b0, 3'b000);
    dchk(32'h10000800, 1'b0, 1'b1, 3'b000);
    dchk(32'h30000000, 1'b0, 1'b1, 3'b100);
    dchk(32'h20000FFF, 1'b0, 1'b0, 3'b111);
    // a write while the enable is low must leave the register untouched
    clk_en_i = 1'b0;
    wr(8'h1C, 4'hF, 32'hABCDE000);
    clk_en_i = 1'b1;
    rd_chk(8'h1C, 32'hFFFFFFFF, 32'h10000000);
    wr(8'h3C, 4'hC, 32'h02000000);
    dchk(32'h10000000, 1'b0, 1'b0, 3'b100);
    dchk(32'h20000000, 1'b0, 1'b0, 3'b111);
    dchk(32'h000001FF, 1'b1, 1'b0, 3'b110);
    dchk(32'h00000200, 1'b1, 1'b0, 3'b000);
    dchk(32'h000000FC, 1'b1, 1'b0, 3'b000);
    dchk(32'h00000150, 1'b1, 1'b1, 3'b000);
    dchk(32'h00000000, 1'b1, 1'b0, 3'b000);
    lat_chk(8'h09, 40, 0, 1'b1);
    lat_chk(8'h20, 2, 0, 1'b0);
    lat_chk(8'h20, 40, 2, 1'b1);
    lat_chk(8'h00, 40, 0, 1'b1);
    print_verdict;
  end
endmodule
